//--- src/sdq_pkg.sv
package sdq_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 1;
  localparam int CTRL_RES8     = 2;
  localparam int CTRL_IRQ_EN   = 3;
  localparam int CTRL_DMA_EN   = 4;
  localparam int CTRL_START    = 8;
  localparam int CTRL_STOP     = 9;

  // status register fields
  localparam int STAT_DONE  = 0;
  localparam int STAT_BUSY  = 1;
  localparam int STAT_VALID = 2;

  // conversion figures
  localparam int CLK_HZ          = 25_000_000;
  localparam int SPS_HI          = 192_000;
  localparam int SPS_LO          = 384_000;
  localparam int RES_HI          = 12;
  localparam int RES_LO          = 8;
  localparam int OSR_LOG2_HI_DEF = 7;
  localparam int OSR_LOG2_LO_DEF = 6;
  localparam int SINC_ORDER      = 4;
  localparam logic [1:0] PRIME_CONV = 2'h3;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_MULTI,
    MODE_CONT,
    MODE_TURBO
  } sdq_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_HOLD
  } sdq_state_t;

  typedef struct packed {
    sdq_mode_t mode;
    logic      res8;
    logic      irq_en;
    logic      dma_en;
  } sdq_cfg_t;

  localparam sdq_cfg_t CFG_RST = '{mode: MODE_SINGLE, res8: 1'b0, irq_en: 1'b0, dma_en: 1'b0};

endpackage

//--- src/sdq_adc_seq.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - four modes: single, multi, continuous, turbo
// - start by control bit or strobe
// - completion sets status done bit
// - eoc high until result is read
// - single mode waits in standby
// - single trigger runs four conversions
// - result valid after fourth conversion
// - after readout single returns to standby
// - continuous first result after three primes
// - continuous results follow without retrigger
// - multi mode resets filter between samples
// - multi mode re-primes before each sample
// - multi sample starts next automatically
// - output depends on last four periods
// - after mux change wait four samples
// - twelve bit setting near 192 ksps
// - eight bit setting doubles the rate
// - serial modulator bits decimated to words
// - fourth order sinc response
// - eoc routed to irq, dma, poll
module sdq_adc_seq
  import sdq_pkg::*;
#(
  parameter int OSR_LOG2_HI = OSR_LOG2_HI_DEF,
  parameter int OSR_LOG2_LO = OSR_LOG2_LO_DEF
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod_bit,
  input  wire logic        soc,
  input  wire logic        mux_chg,
  input  wire logic        dma_ack,
  output logic             eoc,
  output logic             eoc_irq,
  output logic             eoc_dma,
  output logic      [11:0] result_data,
  output logic             busy
);

  localparam int ACC_W = SINC_ORDER * OSR_LOG2_HI + 1;
  localparam int DEC_W = OSR_LOG2_HI;

  sdq_state_t        st_r;
  sdq_cfg_t          cfg_r;
  logic [1:0]        prime_cnt_r;
  logic [DEC_W-1:0]  dec_cnt_r;
  logic [DEC_W-1:0]  osr_max;
  logic              eoc_r;
  logic              eoc_nxt;
  logic [11:0]       result_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              eoc_irq_r;
  logic              eoc_dma_r;
  logic              busy_r;
  logic              setup_ph;
  logic              acc_done;
  logic              wr_ctrl;
  logic              rd_res;
  logic              start_req;
  logic              stop_req;
  logic              tick;
  logic              publish;
  logic              flt_clr;
  logic              run;
  logic              res_clr;
  logic [ACC_W-1:0]  integ_r [0:SINC_ORDER-1];
  logic [ACC_W-1:0]  cdly_r  [0:SINC_ORDER-1];
  logic [ACC_W-1:0]  comb_w  [0:SINC_ORDER];

  // apb handshake: answer is prepared in the setup cycle, taken in the first access cycle
  assign setup_ph = psel && !penable;
  assign acc_done = psel && penable && pready_r;
  assign wr_ctrl  = acc_done && pwrite && (paddr == OFF_CTRL);
  assign rd_res   = acc_done && !pwrite && (paddr == OFF_RESULT);

  assign start_req = (wr_ctrl && pwdata[CTRL_START]) || soc;
  assign stop_req  = wr_ctrl && pwdata[CTRL_STOP];
  assign res_clr   = rd_res || dma_ack;

  // decimation period length selects resolution against rate
  assign osr_max = cfg_r.res8 ? DEC_W'((1 << OSR_LOG2_LO) - 1) : '1;
  assign run     = (st_r == ST_CONV);
  assign tick    = run && (dec_cnt_r == osr_max);
  // a mux switch in the same period discards the result
  assign publish = tick && !mux_chg && (prime_cnt_r == PRIME_CONV);

  // filter restart when a sequence begins, a multi sample re-primes or a turbo result is published
  always_comb
  begin
    flt_clr = 1'b0;
    if (st_r == ST_IDLE && start_req && !stop_req)
    begin
      flt_clr = 1'b1;
    end
    else if (st_r == ST_HOLD && cfg_r.mode == MODE_MULTI && !eoc_r && !stop_req)
    begin
      flt_clr = 1'b1;
    end
    else if (publish && cfg_r.mode == MODE_TURBO)
    begin
      flt_clr = 1'b1;
    end
  end

  // sinc4 decimator: four integrators at bit rate, four combs at result rate
  assign comb_w[0] = integ_r[SINC_ORDER-1];
  for (genvar k = 0; k < SINC_ORDER; k++)
  begin : g_sinc
    if (k == 0)
    begin : g_first
      always_ff @(posedge core_clk)
      begin
        if (rst || flt_clr)
        begin
          integ_r[k] <= '0;
        end
        else if (run)
        begin
          integ_r[k] <= integ_r[k] + {{(ACC_W-1){1'b0}}, mod_bit};
        end
      end
    end
    else
    begin : g_rest
      always_ff @(posedge core_clk)
      begin
        if (rst || flt_clr)
        begin
          integ_r[k] <= '0;
        end
        else if (run)
        begin
          integ_r[k] <= integ_r[k] + integ_r[k-1];
        end
      end
    end
    assign comb_w[k+1] = comb_w[k] - cdly_r[k];
    always_ff @(posedge core_clk)
    begin
      if (rst || flt_clr)
      begin
        cdly_r[k] <= '0;
      end
      else if (tick)
      begin
        cdly_r[k] <= comb_w[k];
      end
    end
  end

  // scale and saturate the comb output to the selected width
  function automatic logic [11:0] pick_result(input logic [ACC_W-1:0] v, input logic r8);
    logic [11:0] w;
    w = '0;
    if (r8)
    begin
      w[RES_LO-1:0] = v[SINC_ORDER*OSR_LOG2_LO] ? '1 :
                      v[SINC_ORDER*OSR_LOG2_LO-1 -: RES_LO];
    end
    else
    begin
      w = v[SINC_ORDER*OSR_LOG2_HI] ? '1 : v[SINC_ORDER*OSR_LOG2_HI-1 -: RES_HI];
    end
    return w;
  endfunction

  // sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
    end
    else if (stop_req)
    begin
      st_r <= ST_IDLE;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
        begin
          if (start_req)
          begin
            st_r <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (publish && (cfg_r.mode == MODE_SINGLE || cfg_r.mode == MODE_MULTI))
          begin
            st_r <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (!eoc_r)
          begin
            st_r <= (cfg_r.mode == MODE_MULTI) ? ST_CONV : ST_IDLE;
          end
        end
      endcase
    end
  end

  // priming counter; triggers while busy do not touch it
  always_ff @(posedge core_clk)
  begin
    if (rst || flt_clr)
    begin
      prime_cnt_r <= '0;
    end
    else if (run && mux_chg)
    begin
      prime_cnt_r <= '0;
    end
    else if (tick && prime_cnt_r != PRIME_CONV)
    begin
      prime_cnt_r <= prime_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || flt_clr || !run || tick)
    begin
      dec_cnt_r <= '0;
    end
    else
    begin
      dec_cnt_r <= dec_cnt_r + 1'b1;
    end
  end

  // done flag: a new result wins over a read in the same cycle
  always_comb
  begin
    eoc_nxt = eoc_r;
    if (publish)
    begin
      eoc_nxt = 1'b1;
    end
    else if (res_clr)
    begin
      eoc_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      eoc_r     <= 1'b0;
      eoc_irq_r <= 1'b0;
      eoc_dma_r <= 1'b0;
    end
    else
    begin
      eoc_r     <= eoc_nxt;
      eoc_irq_r <= eoc_nxt && cfg_r.irq_en;
      eoc_dma_r <= eoc_nxt && cfg_r.dma_en;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      result_r <= '0;
    end
    else if (publish)
    begin
      result_r <= pick_result(comb_w[SINC_ORDER], cfg_r.res8);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= (st_r != ST_IDLE);
    end
  end

  // configuration register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfg_r <= CFG_RST;
    end
    else if (wr_ctrl)
    begin
      cfg_r.mode   <= sdq_mode_t'(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      cfg_r.res8   <= pwdata[CTRL_RES8];
      cfg_r.irq_en <= pwdata[CTRL_IRQ_EN];
      cfg_r.dma_en <= pwdata[CTRL_DMA_EN];
    end
  end

  // apb slave: read data and error prepared during setup
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup_ph;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      if (setup_ph)
      begin
        unique case (paddr)
          OFF_CTRL:
          begin
            prdata_r[CTRL_MODE_MSB:CTRL_MODE_LSB] <= cfg_r.mode;
            prdata_r[CTRL_RES8]   <= cfg_r.res8;
            prdata_r[CTRL_IRQ_EN] <= cfg_r.irq_en;
            prdata_r[CTRL_DMA_EN] <= cfg_r.dma_en;
          end
          OFF_STATUS:
          begin
            prdata_r[STAT_DONE]  <= eoc_r;
            prdata_r[STAT_BUSY]  <= (st_r != ST_IDLE);
            prdata_r[STAT_VALID] <= (prime_cnt_r == PRIME_CONV);
          end
          OFF_RESULT:
          begin
            prdata_r[11:0] <= result_r;
          end
          default:
          begin
            pslverr_r <= 1'b1;
          end
        endcase
      end
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign eoc         = eoc_r;
  assign eoc_irq     = eoc_irq_r;
  assign eoc_dma     = eoc_dma_r;
  assign result_data = result_r;
  assign busy        = busy_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_eoc_sets: assert property (publish |=> eoc && eoc_r)
    else $error("eoc not raised after result");

  chk_eoc_holds: assert property (eoc_r && !res_clr |=> eoc_r)
    else $error("eoc dropped before result read");

  chk_fourth_conv: assert property (publish |-> prime_cnt_r == PRIME_CONV && tick)
    else $error("result published before priming finished");

  chk_standby_wait: assert property (st_r == ST_IDLE && !start_req |=> st_r == ST_IDLE)
    else $error("left standby without a start");

  chk_single_return: assert property (
    st_r == ST_HOLD && cfg_r.mode == MODE_SINGLE && !eoc_r && !stop_req
    |=> st_r == ST_IDLE)
    else $error("single mode did not return to standby");

  chk_turbo_reprime: assert property (
    publish && cfg_r.mode == MODE_TURBO && !stop_req |=> prime_cnt_r == 2'h0 && run)
    else $error("turbo sample not re-primed");

  chk_cont_free: assert property (
    publish && cfg_r.mode == MODE_CONT && !stop_req
    |=> run && prime_cnt_r == PRIME_CONV)
    else $error("continuous mode stopped after result");

  chk_mux_invalid: assert property (run && mux_chg |-> ##1 !publish [*8])
    else $error("result published too soon after mux switch");

  chk_busy_ignore: assert property (
    run && start_req && !tick && !mux_chg && !stop_req |=> $stable(prime_cnt_r) && run)
    else $error("start accepted during busy sequence");

  chk_irq_route: assert property (eoc_irq || eoc_dma |-> eoc_r)
    else $error("routed eoc without done flag");

  cov_single: cover property (publish && cfg_r.mode == MODE_SINGLE ##[1:20] rd_res);
  cov_cont: cover property (publish && cfg_r.mode == MODE_CONT);
  cov_turbo: cover property (publish && cfg_r.mode == MODE_TURBO);
  cov_multi: cover property (st_r == ST_HOLD && cfg_r.mode == MODE_MULTI ##1 flt_clr);

endmodule

//--- test/sdq_far_end.sv
`timescale 1ns/10ps
module sdq_far_end
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ones,
  input  wire logic dma_on,
  input  wire logic eoc_dma,
  output logic      mod_bit,
  output logic      dma_ack
);
  logic [1:0] cnt_r;

  // modulator stream pinned to one rail gives a known full-scale result
  assign mod_bit = ones;

  // dma takes the result three cycles after its request, one-cycle ack
  always_ff @(posedge core_clk)
  begin
    if (rst || !eoc_dma || !dma_on || dma_ack)
    begin
      cnt_r   <= 2'h0;
      dma_ack <= 1'b0;
    end
    else if (cnt_r == 2'h2)
      dma_ack <= 1'b1;
    else
      cnt_r <= cnt_r + 2'h1;
  end
endmodule

//--- test/tb_sdq_adc_seq.sv
`timescale 1ns/10ps
module tb_sdq_adc_seq
  import sdq_pkg::*;
;
  localparam int P = 8;

  logic        core_clk, rst, psel, penable, pwrite, soc, mux_chg, ones, dma_on, err;
  logic        pready, pslverr, mod_bit, dma_ack, eoc, eoc_irq, eoc_dma, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] result_data;
  int          n_errors, n_compared, n;

  sdq_adc_seq #(.OSR_LOG2_HI(3), .OSR_LOG2_LO(2)) dut
  (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mod_bit, .soc, .mux_chg, .dma_ack, .eoc, .eoc_irq, .eoc_dma,
    .result_data, .busy
  );

  sdq_far_end far
  (
    .core_clk, .rst, .ones, .dma_on, .eoc_dma, .mod_bit, .dma_ack
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle pulse on the start strobe or the mux-switch flag
  task automatic strobe(input bit mux);
    @(posedge core_clk);
    if (mux)
      mux_chg <= 1'b1;
    else
      soc <= 1'b1;
    @(posedge core_clk);
    mux_chg <= 1'b0;
    soc     <= 1'b0;
  endtask

  task automatic wait_eoc();
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (eoc !== 1'b1 && n < 300);
    if (eoc !== 1'b1)
    begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    soc = 1'b0;
    mux_chg = 1'b0;
    ones = 1'b1;
    dma_on = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    apb(0, OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(0, 8'h0C, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    // single, software start, second start arrives mid-sequence
    apb(1, OFF_CTRL, 32'h100);
    apb(0, OFF_STATUS, 32'h0);
    check(rd & 32'h3, 32'h2);
    strobe(0);
    wait_eoc();
    // counting starts five edges after the start write
    check(n, 4 * P - 5);
    apb(0, OFF_STATUS, 32'h0);
    check(rd[0], 1'b1);
    apb(0, OFF_RESULT, 32'h0);
    check(rd, 32'hFFF);
    check(result_data, 32'hFFF);
    idle(1);
    check(eoc, 1'b0);
    idle(40);
    check({eoc, busy}, 2'h0);
    // eight-bit setting, hardware strobe
    apb(1, OFF_CTRL, 32'h4);
    strobe(0);
    wait_eoc();
    check(n, 2 * P);
    apb(0, OFF_RESULT, 32'h0);
    check(rd, 32'hFF);
    // multi: waits for the read, then re-primes by itself
    apb(1, OFF_CTRL, 32'h101);
    wait_eoc();
    check(n, 4 * P);
    idle(2 * P);
    check(eoc, 1'b1);
    apb(0, OFF_RESULT, 32'h0);
    wait_eoc();
    check(n, 4 * P + 1);
    // take the result so the done flag is clear before the next mode
    apb(0, OFF_RESULT, 32'h0);
    check(rd, 32'hFFF);
    apb(1, OFF_CTRL, 32'h200);
    // continuous on one steady input, mux left alone
    ones <= 1'b0;
    apb(1, OFF_CTRL, 32'h102);
    wait_eoc();
    check(n, 4 * P);
    apb(0, OFF_RESULT, 32'h0);
    check(rd, 32'h0);
    wait_eoc();
    check(n >= P - 3 && n <= P, 1'b1);
    apb(0, OFF_RESULT, 32'h0);
    check(rd, 32'h0);
    apb(1, OFF_CTRL, 32'h200);
    // turbo with both event routes; the dma side consumes results
    dma_on <= 1'b1;
    apb(1, OFF_CTRL, 32'h11B);
    wait_eoc();
    check({eoc_irq, eoc_dma}, 2'h3);
    idle(5);
    check(eoc, 1'b0);
    wait_eoc();
    check(n, 4 * P - 5);
    strobe(1);
    idle(3);
    check(eoc, 1'b0);
    wait_eoc();
    check(n >= 3 * P, 1'b1);
    // start bit is not stored, the rest reads back
    apb(0, OFF_CTRL, 32'h0);
    check(rd, 32'h1B);
    apb(1, OFF_CTRL, 32'h200);
    summarize();
  end
endmodule
